// File: dv/encoder_model.sv
// Behavioural incremental encoder driving the phase and index pins
`timescale 1ns/1ps
module encoder_model (
   // Clock
   input  wire logic         clk,
   // Encoder pins
   output qe_pkg::enc_pins_t pins
);
   import qe_pkg::*;
   // ==========
   // Quadrature state, kept in step with the pins
   logic [1:0] ph_q;
   initial begin
      ph_q = 2'h0;
      pins = '0;
   end
   // Change after an edge, then hold; gap sets prompt or slow motion
   task automatic drive(input logic a, input logic b, input logic i, input int gap);
      ph_q = {b, a ^ b};
      @(posedge clk);
      pins <= '{phase_a_in: a, phase_b_in: b, index_in: i};
      repeat (gap) @(posedge clk);
   endtask : drive
   // Forward order 00,10,11,01 so A leads B
   task automatic step(input logic fwd, input int gap);
      logic [1:0] n;
      n = fwd ? ph_q + 2'h1 : ph_q - 2'h1;
      drive(n[1] ^ n[0], n[1], 1'b0, gap);
   endtask : step
   // Index only while both phases rest low
   task automatic index_pulse();
      drive(1'b0, 1'b0, 1'b1, 6);
      drive(1'b0, 1'b0, 1'b0, 6);
   endtask : index_pulse
endmodule : encoder_model

// File: dv/testbench.sv
// Self-checking bench for the quadrature decoder
`timescale 1ns/1ps
module testbench;
   import qe_pkg::*;
   // ==========
   // Signals
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        ce = 1'b1;
   logic        cpu_sleep = 1'b0;
   logic        cpu_idle = 1'b0;
   avmm_req_t   avs_req = '0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   enc_pins_t   enc_pins;
   logic        count_direction;
   logic        module_irq_flag;
   int          miscompares = 0;
   int          compares = 0;
   int          cycles = 0;
   int          seed = 32'h19cf;
   logic [15:0] pos;
   logic [15:0] mx;
   logic        up;
   logic        irq;
   logic [15:0] ctl_t [5] = '{16'h0604, 16'h0604, 16'h0600, 16'h0404, 16'h0404};
   logic [15:0] flt_t [5] = '{16'h0000, 16'h0600, 16'h0000, 16'h0400, 16'h0200};
   logic        rst_t [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   logic        irq_t [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

   always #2.5 clk = ~clk;
   quad_decoder dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cpu_sleep(cpu_sleep),
      .cpu_idle(cpu_idle), .avs_req(avs_req), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .enc_pins(enc_pins),
      .count_direction(count_direction), .module_irq_flag(module_irq_flag));
   encoder_model enc (.clk(clk), .pins(enc_pins));

   // ==========
   // Checking and bus tasks
   task automatic stop_test();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   // Hang guard, well above the roughly 1500 cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares = miscompares + 1;
         stop_test();
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares = compares + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Request held until waitrequest is sampled low at a rising edge; the hang guard ends a stall
   task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d,
                      output logic [15:0] q);
      @(posedge clk);
      avs_req <= '{read: !w, write: w, address: a, byteenable: 4'h3,
                   writedata: {16'h0000, d}};
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata[15:0];
      avs_req <= '0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rchk(input string nm, input logic [5:0] a, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk(nm, e, q);
   endtask : rchk
   task automatic pchk(input logic ed, input logic ef);
      @(negedge clk);
      chk("direction", {15'h0, ed}, {15'h0, count_direction});
      chk("irq flag", {15'h0, ef}, {15'h0, module_irq_flag});
   endtask : pchk
   task automatic pulse(input logic b);
      enc.drive(1'b1, b, 1'b0, 6);
      enc.drive(1'b0, b, 1'b0, 6);
   endtask : pulse
   function automatic logic [15:0] nxt(input logic [15:0] p, input logic u,
                                       input logic [15:0] m);
      if (u)
         return (p == m) ? 16'h0000 : p + 16'h0001;
      return (p == 16'h0000) ? m : p - 16'h0001;
   endfunction : nxt

   // ==========
   // Scenarios
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      rchk("ctrl", OFS_CTRL, 16'h0000);
      rchk("filt", OFS_FILT, 16'h0000);
      rchk("pos", OFS_POS, POS_RESET);
      rchk("max", OFS_MAX, MAX_RESET);
      rchk("sts", OFS_STATUS, 16'h0000);
      rchk("unmapped", 6'h14, 16'h0000);
      $display("test reset done");
      mx = 16'(($random(seed) & 7) + 3);
      pos = 16'h0000;
      irq = 1'b0;
      wr(OFS_MAX, mx);
      wr(OFS_CTRL, 16'h0700);
      for (int k = 0; k < 40; k++) begin
         up = 1'($random(seed) & 1);
         irq = irq | (up ? pos == mx : pos == 16'h0000);
         pos = nxt(pos, up, mx);
         enc.step(up, 6 + ($random(seed) & 7));
         pchk(up, irq);
         rchk("pos", OFS_POS, pos);
         rchk("ctrl", OFS_CTRL, {4'h0, up, 11'h700});
      end
      wr(OFS_STATUS, 16'h0000);
      pchk(up, 1'b0);
      while (enc.ph_q != 2'h0)
         enc.step(1'b1, 6);
      $display("test x4 walk done");
      wr(OFS_MAX, 16'hffff);
      wr(OFS_CTRL, 16'h0500);
      wr(OFS_POS, 16'h0000);
      for (int k = 0; k < 8; k++)
         enc.step(1'b1, 6);
      rchk("pos", OFS_POS, 16'h0004);
      for (int k = 0; k < 5; k++) begin
         wr(OFS_CTRL, ctl_t[k]);
         wr(OFS_FILT, flt_t[k]);
         wr(OFS_POS, 16'h1234);
         wr(OFS_STATUS, 16'h0000);
         enc.index_pulse();
         rchk("pos", OFS_POS, rst_t[k] ? 16'h0000 : 16'h1234);
         pchk(1'b1, irq_t[k]);
      end
      $display("test x2 and index done");
      wr(OFS_FILT, 16'h0000);
      wr(OFS_CTRL, 16'h0600);
      wr(OFS_POS, 16'hffff);
      enc.step(1'b1, 6);
      rchk("pos", OFS_POS, 16'h0000);
      rchk("ctrl", OFS_CTRL, 16'h8e00);
      pchk(1'b1, 1'b1);
      wr(OFS_CTRL, 16'h0600);
      rchk("ctrl", OFS_CTRL, 16'h0e00);
      wr(OFS_FILT, 16'h0100);
      wr(OFS_MAX, 16'h00ff);
      wr(OFS_POS, 16'h0100);
      wr(OFS_STATUS, 16'h0000);
      enc.step(1'b0, 6);
      rchk("ctrl", OFS_CTRL, 16'h8600);
      pchk(1'b0, 1'b0);
      wr(OFS_FILT, 16'h0000);
      wr(OFS_POS, 16'h0000);
      enc.step(1'b0, 6);
      rchk("pos", OFS_POS, 16'hffff);
      pchk(1'b0, 1'b0);
      $display("test count error done");
      wr(OFS_POS, 16'h0005);
      wr(OFS_MAX, 16'h0007);
      wr(OFS_CTRL, 16'h0900);
      rchk("pos", OFS_POS, 16'h0005);
      for (int k = 0; k < 3; k++)
         pulse(1'b0);
      rchk("pos", OFS_POS, 16'h0000);
      rchk("sts", OFS_STATUS, 16'h0001);
      wr(OFS_CTRL, 16'h0100);
      pulse(1'b0);
      rchk("pos", OFS_POS, 16'h0007);
      wr(OFS_CTRL, 16'h0101);
      pulse(1'b1);
      rchk("pos", OFS_POS, 16'h0000);
      $display("test timer done");
      wr(OFS_CTRL, 16'h0700);
      wr(OFS_MAX, 16'hffff);
      wr(OFS_POS, 16'h0010);
      cpu_sleep <= 1'b1;
      enc.step(1'b1, 6);
      enc.step(1'b0, 6);
      cpu_sleep <= 1'b0;
      rchk("pos", OFS_POS, 16'h0010);
      cpu_idle <= 1'b1;
      enc.step(1'b1, 6);
      rchk("pos", OFS_POS, 16'h0011);
      wr(OFS_CTRL, 16'h2700);
      enc.step(1'b1, 6);
      enc.step(1'b0, 6);
      rchk("pos", OFS_POS, 16'h0011);
      cpu_idle <= 1'b0;
      $display("test sleep idle done");
      wr(OFS_CTRL, 16'h0700);
      wr(OFS_FILT, 16'h00b0);
      enc.drive(1'b0, 1'b1, 1'b0, 60);
      wr(OFS_POS, 16'h0000);
      enc.drive(1'b1, 1'b1, 1'b0, 8);
      enc.drive(1'b0, 1'b1, 1'b0, 60);
      rchk("pos", OFS_POS, 16'h0000);
      enc.step(1'b1, 60);
      rchk("pos", OFS_POS, 16'h0001);
      wr(OFS_FILT, 16'h0080);
      enc.drive(1'b1, 1'b0, 1'b0, 1);
      enc.drive(1'b0, 1'b0, 1'b0, 20);
      rchk("pos", OFS_POS, 16'h0001);
      rchk("ctrl", OFS_CTRL, 16'h0f00);
      $display("test filter done");
      stop_test();
   end
endmodule : testbench

// File: rtl/quad_decoder.sv
// Quadrature encoder decoder with position counter and timer mode
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - A leading B means forward direction
// - Index modes: flag count error at limit
// - Error interrupt disable bit suppresses it
// - Keep counting after error, silent wrap
// - Error flag sticky, software read/write
// - Reset enable bit gates index reset
// - Index reset needs phase match, x4
// - x2 match picks phase and level
// - Index modes interrupt on index, not wrap
// - Direction on pin and status bit
// - x2 counts both edges of A only
// - Codes 100/110 index, 101/111 max reset
// - x4 counts every edge of A and B
// - Filter changes after three stable samples
// - Filter clock divided by three-bit field
// - Filtered path used only when enabled
// - Mode 001 is timer with period match
// - Mode change keeps count register
// - Timer direction from pin B or software
// - Direction one counts up, zero down
// - External clock synchronised before counting
// - Sleep halts counting and filtering; bus access stays live
// - Idle halts only when stop bit set
module quad_decoder #(
   parameter int CNT_W = 16
) (
   // Clock, reset, enable
   input  wire logic            clk,
   input  wire logic            sys_rst,
   input  wire logic            ce,
   // Power state
   input  wire logic            cpu_sleep,
   input  wire logic            cpu_idle,
   // Avalon-MM slave
   input  wire qe_pkg::avmm_req_t avs_req,
   output logic [31:0]          avs_readdata,
   output logic                 avs_waitrequest,
   // Encoder pins
   input  wire qe_pkg::enc_pins_t enc_pins,
   output logic                 count_direction,
   output logic                 module_irq_flag
);
   import qe_pkg::*;

   if (CNT_W != 16) begin : g_cnt_w_check
      $error("CNT_W must be 16");
   end

   // ======================================================
   // Register state
   logic             count_error_flag_q, stop_in_idle_q, sw_dir_q;
   logic             index_reset_enable_q, direction_source_sel_q;
   decoder_mode_t    decoder_mode_sel_q;
   logic [1:0]       index_match_value_q;
   logic             count_error_irq_disable_q, filter_output_enable_q;
   logic [2:0]       filter_clock_div_q;
   logic [15:0]      position_count_reg_q, max_count_reg_q;
   logic             irq_q, resp_q;
   logic [31:0]      rdata_q;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction : merge

   // ======================================================
   // Bus handshake: one wait cycle, then accept
   logic req, acc, wr_acc;
   assign req             = avs_req.read | avs_req.write;
   assign avs_waitrequest = req & ~(resp_q & ce);
   assign acc             = req & resp_q & ce;
   assign wr_acc          = acc & avs_req.write;
   assign avs_readdata    = rdata_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         resp_q <= 1'b0;
      end else if (ce) begin
         resp_q <= req & ~resp_q;
      end
   end

   function automatic logic wr_at(input logic [5:0] ofs);
      wr_at = wr_acc & (avs_req.address == ofs);
   endfunction : wr_at

   logic [15:0] ctrl_wd;
   assign ctrl_wd = merge(16'h0000, avs_req.writedata, avs_req.byteenable);

   // ======================================================
   // Pin synchronisers
   enc_pins_t s1_q, s2_q;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= '0;
         s2_q <= '0;
      end else if (ce) begin
         s1_q <= enc_pins;
         s2_q <= s1_q;
      end
   end

   // ======================================================
   // Run gating: sleep always stops, idle only if asked
   logic run;
   assign run = ce & ~cpu_sleep & ~(cpu_idle & stop_in_idle_q);

   // ======================================================
   // Filter clock divider
   logic [6:0] div_cnt_q;
   logic       ftick;
   assign ftick = (div_cnt_q == 7'((8'h01 << filter_clock_div_q) - 8'h01));
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt_q <= '0;
      end else if (run) begin
         div_cnt_q <= ftick ? 7'h00 : div_cnt_q + 7'h01;
      end
   end

   // ======================================================
   // Three-sample filters
   logic [2:0] raw, filt_q, sel;
   logic [1:0] hist_q [3];
   assign raw = {s2_q.phase_a_in, s2_q.phase_b_in, s2_q.index_in};

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         filt_q <= '0;
         for (int i = 0; i < 3; i++) hist_q[i] <= '0;
      end else if (run && ftick) begin
         for (int i = 0; i < 3; i++) begin
            hist_q[i] <= {hist_q[i][0], raw[i]};
            if (hist_q[i] == {2{raw[i]}}) filt_q[i] <= raw[i];
         end
      end
   end

   // Filters off after reset, so the raw synced pins are used
   assign sel = filter_output_enable_q ? filt_q : raw;

   // ======================================================
   // Edge and direction decoding
   logic a_q, b_q, a_n, b_n, a_edge, b_edge, enc_up, cnt_pulse;
   logic enc_mode, x4, idx_mode, max_mode, tmr_mode;
   assign a_n      = sel[2];
   assign b_n      = sel[1];
   assign a_edge   = a_n ^ a_q;
   assign b_edge   = b_n ^ b_q;
   assign enc_up   = a_n ^ b_q;
   assign enc_mode = decoder_mode_sel_q[2];
   assign x4       = decoder_mode_sel_q[1];
   assign idx_mode = enc_mode & ~decoder_mode_sel_q[0];
   assign max_mode = enc_mode & decoder_mode_sel_q[0];
   assign tmr_mode = (decoder_mode_sel_q == MODE_TIMER);
   assign cnt_pulse = enc_mode & (x4 ? (a_edge | b_edge) : a_edge);

   // Encoder direction latched on every A or B edge, counted or not
   logic enc_dir_q, tmr_up, cur_up;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         enc_dir_q <= 1'b0;
      end else if (run && enc_mode && (a_edge || b_edge)) begin
         enc_dir_q <= enc_up;
      end
   end
   assign tmr_up = direction_source_sel_q ? b_n : sw_dir_q;
   assign cur_up = tmr_mode ? tmr_up : enc_dir_q;
   assign count_direction = cur_up;

   // ======================================================
   // Index qualification
   logic idx_match, idx_qual, idx_qual_q, idx_event;
   assign idx_match = x4 ?
      ((b_n == index_match_value_q[1]) && (a_n == index_match_value_q[0])) :
      ((index_match_value_q[1] ? b_n : a_n) == index_match_value_q[0]);
   assign idx_qual  = sel[0] & idx_match;
   assign idx_event = idx_mode & idx_qual & ~idx_qual_q;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         a_q        <= 1'b0;
         b_q        <= 1'b0;
         idx_qual_q <= 1'b0;
      end else if (run) begin
         a_q        <= a_n;
         b_q        <= b_n;
         idx_qual_q <= idx_qual;
      end
   end

   // ======================================================
   // Position counter and events
   logic tmr_tick, err_hit, wrap_evt;
   assign tmr_tick = tmr_mode & a_n & ~a_q;
   assign err_hit  = idx_mode & cnt_pulse &
                     (enc_up ? (position_count_reg_q == 16'hffff)
                             : (position_count_reg_q == max_count_reg_q + 16'h0001));

   logic [15:0] pos_d;
   logic        per_evt, wrap_cnt, step_up;
   assign step_up  = tmr_mode ? tmr_up : enc_up;
   assign wrap_cnt = (max_mode & cnt_pulse) | tmr_tick;
   assign per_evt  = wrap_cnt & (step_up ? (position_count_reg_q == max_count_reg_q)
                                         : (position_count_reg_q == 16'h0000));
   always_comb begin
      if (idx_event && index_reset_enable_q) begin
         pos_d = 16'h0000;
      end else if (per_evt) begin
         pos_d = step_up ? 16'h0000 : max_count_reg_q;
      end else if (cnt_pulse || tmr_tick) begin
         // Natural wrap in index modes stays silent
         pos_d = step_up ? position_count_reg_q + 16'h0001
                         : position_count_reg_q - 16'h0001;
      end else begin
         pos_d = position_count_reg_q;
      end
   end
   assign wrap_evt = per_evt | idx_event | (err_hit & ~count_error_irq_disable_q);

   // Mode writes never touch the count register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         position_count_reg_q <= POS_RESET;
         max_count_reg_q      <= MAX_RESET;
      end else if (ce) begin
         if (wr_at(OFS_POS)) begin
            position_count_reg_q <= merge(position_count_reg_q, avs_req.writedata,
                                          avs_req.byteenable);
         end else if (run) begin
            position_count_reg_q <= pos_d;
         end
         if (wr_at(OFS_MAX)) begin
            max_count_reg_q <= merge(max_count_reg_q, avs_req.writedata, avs_req.byteenable);
         end
      end
   end

   // ======================================================
   // Sticky flags: a hardware set beats a software clear
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         count_error_flag_q <= 1'b0;
         irq_q              <= 1'b0;
      end else if (ce) begin
         if (run && err_hit) begin
            count_error_flag_q <= 1'b1;
         end else if (wr_at(OFS_CTRL) && avs_req.byteenable[1]) begin
            count_error_flag_q <= ctrl_wd[CTL_ERR_BIT];
         end
         if (run && wrap_evt) begin
            irq_q <= 1'b1;
         end else if (wr_at(OFS_STATUS) && avs_req.byteenable[0]) begin
            irq_q <= avs_req.writedata[STS_IRQ_BIT];
         end
      end
   end
   assign module_irq_flag = irq_q;

   // ======================================================
   // Control and filter registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stop_in_idle_q            <= 1'b0;
         sw_dir_q                  <= 1'b0;
         decoder_mode_sel_q        <= MODE_OFF;
         index_reset_enable_q      <= 1'b0;
         direction_source_sel_q    <= 1'b0;
         index_match_value_q       <= 2'b00;
         count_error_irq_disable_q <= 1'b0;
         filter_output_enable_q    <= 1'b0;
         filter_clock_div_q        <= 3'b000;
      end else if (wr_at(OFS_CTRL)) begin
         if (avs_req.byteenable[1]) begin
            stop_in_idle_q     <= ctrl_wd[CTL_SIDL_BIT];
            sw_dir_q           <= ctrl_wd[CTL_DIR_BIT];
            decoder_mode_sel_q <= decoder_mode_t'(ctrl_wd[CTL_MODE_LSB +: 3]);
         end
         if (avs_req.byteenable[0]) begin
            index_reset_enable_q   <= ctrl_wd[CTL_IRES_BIT];
            direction_source_sel_q <= ctrl_wd[CTL_DSRC_BIT];
         end
      end else if (wr_at(OFS_FILT)) begin
         if (avs_req.byteenable[1]) begin
            index_match_value_q       <= ctrl_wd[FLT_IMV_LSB +: 2];
            count_error_irq_disable_q <= ctrl_wd[FLT_COUNT_ERROR_IRQ_DISABLE_BIT];
         end
         if (avs_req.byteenable[0]) begin
            filter_output_enable_q <= ctrl_wd[FLT_OEN_BIT];
            filter_clock_div_q     <= ctrl_wd[FLT_DIV_LSB +: 3];
         end
      end
   end

   // ======================================================
   // Read data, captured in the wait cycle
   logic [15:0] ctrl_rd, filt_rd;
   always_comb begin
      ctrl_rd = 16'h0000;
      ctrl_rd[CTL_ERR_BIT]         = count_error_flag_q;
      ctrl_rd[CTL_SIDL_BIT]        = stop_in_idle_q;
      ctrl_rd[CTL_DIR_BIT]         = cur_up;
      ctrl_rd[CTL_MODE_LSB +: 3]   = decoder_mode_sel_q;
      ctrl_rd[CTL_IRES_BIT]        = index_reset_enable_q;
      ctrl_rd[CTL_DSRC_BIT]        = direction_source_sel_q;
      filt_rd = 16'h0000;
      filt_rd[FLT_IMV_LSB +: 2]    = index_match_value_q;
      filt_rd[FLT_COUNT_ERROR_IRQ_DISABLE_BIT]        = count_error_irq_disable_q;
      filt_rd[FLT_OEN_BIT]         = filter_output_enable_q;
      filt_rd[FLT_DIV_LSB +: 3]    = filter_clock_div_q;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else if (ce && avs_req.read && !resp_q) begin
         if (avs_req.address == OFS_CTRL) begin
            rdata_q <= {16'h0000, ctrl_rd};
         end else if (avs_req.address == OFS_FILT) begin
            rdata_q <= {16'h0000, filt_rd};
         end else if (avs_req.address == OFS_POS) begin
            rdata_q <= {16'h0000, position_count_reg_q};
         end else if (avs_req.address == OFS_MAX) begin
            rdata_q <= {16'h0000, max_count_reg_q};
         end else if (avs_req.address == OFS_STATUS) begin
            rdata_q <= {31'h0000_0000, irq_q};
         end else begin
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // ======================================================
   // Checks
   AST_ERR_SET: assert property (@(posedge clk) disable iff (sys_rst)
      run && err_hit |=> count_error_flag_q) else $error("count error not flagged");
   AST_COUNT_ERROR_IRQ_DISABLE: assert property (@(posedge clk) disable iff (sys_rst)
      run && err_hit && count_error_irq_disable_q && !idx_event && !per_evt && !irq_q
      |=> !irq_q) else $error("disabled error raised irq");
   AST_IDX_RST: assert property (@(posedge clk) disable iff (sys_rst)
      run && idx_event && index_reset_enable_q && !wr_at(OFS_POS)
      |=> position_count_reg_q == 16'h0000 && irq_q) else $error("index reset missed");
   AST_X2_A_ONLY: assert property (@(posedge clk) disable iff (sys_rst)
      enc_mode && !x4 && !a_edge |-> !cnt_pulse) else $error("x2 counted B edge");
   AST_MAX_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
      run && max_mode && cnt_pulse && enc_up && position_count_reg_q == max_count_reg_q
      && !wr_at(OFS_POS) |=> position_count_reg_q == 16'h0000 && irq_q)
      else $error("max wrap wrong");
   AST_TMR_UP: assert property (@(posedge clk) disable iff (sys_rst)
      run && tmr_tick && tmr_up && position_count_reg_q != max_count_reg_q
      && !wr_at(OFS_POS)
      |=> position_count_reg_q == $past(position_count_reg_q) + 16'h0001)
      else $error("timer did not count up");
   AST_SLEEP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      cpu_sleep && !wr_at(OFS_POS) |=> $stable(position_count_reg_q))
      else $error("count moved in sleep");
   AST_FILT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      run && ftick && hist_q[2] != {2{raw[2]}} |=> $stable(filt_q[2]))
      else $error("filter changed early");
   AST_IRQ_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
      irq_q && !wr_at(OFS_STATUS) |=> irq_q) else $error("irq flag dropped");
endmodule : quad_decoder

// File: shared/qe_pkg.sv
// Shared constants and carrier types for the quadrature decoder
package qe_pkg;
   // ======================================================
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL   = 6'h00;
   localparam logic [5:0] OFS_FILT   = 6'h04;
   localparam logic [5:0] OFS_POS    = 6'h08;
   localparam logic [5:0] OFS_MAX    = 6'h0c;
   localparam logic [5:0] OFS_STATUS = 6'h10;
   // ======================================================
   // Control register fields
   localparam int CTL_ERR_BIT   = 15;
   localparam int CTL_SIDL_BIT  = 13;
   localparam int CTL_DIR_BIT   = 11;
   localparam int CTL_MODE_LSB  = 8;
   localparam int CTL_IRES_BIT  = 2;
   localparam int CTL_DSRC_BIT  = 0;
   // ======================================================
   // Filter register fields
   localparam int FLT_IMV_LSB   = 9;
   localparam int FLT_COUNT_ERROR_IRQ_DISABLE_BIT  = 8;
   localparam int FLT_OEN_BIT   = 7;
   localparam int FLT_DIV_LSB   = 4;
   // ======================================================
   // Status register fields and reset values
   localparam int STS_IRQ_BIT   = 0;
   localparam logic [15:0] POS_RESET = 16'h0000;
   localparam logic [15:0] MAX_RESET = 16'hffff;
   localparam int FILT_STABLE   = 3;
   // ======================================================
   // Mode codes
   typedef enum logic [2:0] {
      MODE_OFF     = 3'b000,
      MODE_TIMER   = 3'b001,
      MODE_X2_IDX  = 3'b100,
      MODE_X2_MAX  = 3'b101,
      MODE_X4_IDX  = 3'b110,
      MODE_X4_MAX  = 3'b111
   } decoder_mode_t;
   // ======================================================
   // Carriers
   typedef struct packed {
      logic        read;
      logic        write;
      logic [5:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } avmm_req_t;
   typedef struct packed {
      logic phase_a_in;
      logic phase_b_in;
      logic index_in;
   } enc_pins_t;
endpackage : qe_pkg
